// ### sim/lcdd_panel_model.sv
`timescale 1ns/1ps
module lcdd_panel_model
(
  input wire clk_in,
  input wire [3:0] com_sel_in,
  input wire [19:0] seg_on_in,
  input wire drive_en_in,
  output reg [79:0] lit_out
);
  integer s;
  integer c;
  initial lit_out = 80'h0;
  // a cell only changes while its common carries select
  always @(posedge clk_in)
  begin
    for (s = 0; s < 20; s = s + 1)
    begin
      for (c = 0; c < 4; c = c + 1)
      begin
        if (com_sel_in[c])
        begin
          lit_out[s*4+c] <= drive_en_in & seg_on_in[s];
        end
      end
    end
  end
endmodule // lcdd_panel_model

// ### sim/lcdd_top_sva.sv
`timescale 1ns/1ps
module lcdd_top_sva
#(
  parameter [9:0] DC_PAIR_MASK = 10'h000
)
(
  input wire REF_CLK_IN,
  input wire RST_N_IN,
  input wire PRS_TICK_IN,
  input wire SLEEP_IN,
  input wire [15:0] MEM_ADDR_IN,
  input wire [3:0] MEM_WDATA_IN,
  input wire MEM_WR_IN,
  input wire MEM_RD_IN,
  input wire [3:0] MEM_RDATA_OUT,
  input wire [3:0] COM_SELECT_OUT,
  input wire [3:0] COM_IN_USE_OUT,
  input wire [19:0] SEG_ON_OUT,
  input wire [19:0] SEG_DC_MODE_OUT,
  input wire [19:0] SEG_DC_LEVEL_OUT,
  input wire DRIVE_EN_OUT,
  input wire STATIC_MODE_OUT,
  input wire POLARITY_OUT,
  input wire FRAME_OUT
);
  // ------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------
  wire [19:0] dc_exp;
  reg [12:0] tick_cnt_r;
  reg dirty_r;
  // frames that saw a duty write, sleep or drive off are not timed
  wire dirty_set = SLEEP_IN | !DRIVE_EN_OUT |
    (MEM_WR_IN && MEM_ADDR_IN == 16'hff60);
  genvar n;
  generate
    for (n = 0; n < 10; n = n + 1)
    begin : g_dc
      assign dc_exp[2*n+1:2*n] = {2{DC_PAIR_MASK[n]}};
    end
  endgenerate
  always @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      tick_cnt_r <= 13'h0;
      dirty_r <= 1'b1;
    end
    else if (FRAME_OUT)
    begin
      tick_cnt_r <= {12'h0, PRS_TICK_IN};
      dirty_r <= dirty_set;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + {12'h0, PRS_TICK_IN};
      dirty_r <= dirty_r | dirty_set;
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  property p_off;
    !DRIVE_EN_OUT |-> SEG_ON_OUT == 20'h0 && COM_SELECT_OUT == 4'h0;
  endproperty
  a_off: assert property (p_off)
    else $error("drive off but outputs active");
  property p_sleep;
    SLEEP_IN |=> !DRIVE_EN_OUT;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep left drive on");
  property p_allon;
    (MEM_WR_IN && MEM_ADDR_IN == 16'hff61 && MEM_WDATA_IN[1]) ##2
      DRIVE_EN_OUT |-> (SEG_ON_OUT | SEG_DC_MODE_OUT) == 20'hfffff;
  endproperty
  a_allon: assert property (p_allon)
    else $error("all-on not shown");
  property p_alloff;
    (MEM_WR_IN && MEM_ADDR_IN == 16'hff61 && MEM_WDATA_IN[2:1] == 2'h2)
      ##2 1'b1 |-> (SEG_ON_OUT & ~SEG_DC_MODE_OUT) == 20'h0;
  endproperty
  a_alloff: assert property (p_alloff)
    else $error("all-off not shown");
  property p_dc;
    $past(RST_N_IN, 2) |-> SEG_DC_MODE_OUT == dc_exp &&
      (SEG_DC_LEVEL_OUT & ~SEG_DC_MODE_OUT) == 20'h0;
  endproperty
  a_dc: assert property (p_dc)
    else $error("dc pin pairing wrong");
  property p_rd;
    MEM_RD_IN && MEM_ADDR_IN == 16'hff60 |=> !MEM_RDATA_OUT[1];
  endproperty
  a_rd: assert property (p_rd)
    else $error("unused bit read as one");
  property p_com;
    DRIVE_EN_OUT && !STATIC_MODE_OUT |-> $onehot(COM_SELECT_OUT) &&
      (COM_SELECT_OUT & ~COM_IN_USE_OUT) == 4'h0 &&
      COM_IN_USE_OUT inside {4'hf, 4'h7, 4'h3};
  endproperty
  a_com: assert property (p_com)
    else $error("bad common selection");
  property p_static;
    DRIVE_EN_OUT && STATIC_MODE_OUT |-> COM_SELECT_OUT == COM_IN_USE_OUT;
  endproperty
  a_static: assert property (p_static)
    else $error("static commons wrong");
  property p_frame;
    FRAME_OUT && !dirty_r |->
      tick_cnt_r == (COM_IN_USE_OUT == 4'h7 ? 13'hc00 : 13'h1000);
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame length wrong");
  property p_pol;
    FRAME_OUT |-> POLARITY_OUT != $past(POLARITY_OUT);
  endproperty
  a_pol: assert property (p_pol)
    else $error("polarity did not flip at frame start");
  property p_pol_hold;
    !FRAME_OUT |-> POLARITY_OUT == $past(POLARITY_OUT);
  endproperty
  a_pol_hold: assert property (p_pol_hold)
    else $error("polarity changed inside a frame");
endmodule // lcdd_top_sva

bind lcdd_top lcdd_top_sva #(.DC_PAIR_MASK(DC_PAIR_MASK)) u_sva (.*);

// ### sim/test_lcdd_top.sv
`timescale 1ns/1ps
module test_lcdd_top;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg sleep = 1'b0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [15:0] addr = 16'h0;
  reg [3:0] wdata = 4'h0;
  wire [3:0] rdata;
  wire [3:0] com_sel;
  wire [3:0] com_use;
  wire [19:0] seg_on;
  wire [19:0] dc_mode;
  wire [19:0] dc_lvl;
  wire drive_en;
  wire frame;
  wire [79:0] lit;
  integer err_count = 0;
  integer cmp_count = 0;
  integer n;
  integer cyc;
  reg [79:0] pat;
  always #12.5 clk = ~clk;
  // pins 0,1 and 18,19 are dc outputs
  lcdd_top #(.DC_PAIR_MASK(10'h201)) dut (
    .REF_CLK_IN(clk),
    .RST_N_IN(rst_n),
    .PRS_TICK_IN(1'b1),
    .SLEEP_IN(sleep),
    .MEM_ADDR_IN(addr),
    .MEM_WDATA_IN(wdata),
    .MEM_WR_IN(wr),
    .MEM_RD_IN(rd),
    .MEM_RDATA_OUT(rdata),
    .COM_SELECT_OUT(com_sel),
    .COM_IN_USE_OUT(com_use),
    .SEG_ON_OUT(seg_on),
    .SEG_DC_MODE_OUT(dc_mode),
    .SEG_DC_LEVEL_OUT(dc_lvl),
    .DRIVE_EN_OUT(drive_en),
    .STATIC_MODE_OUT(),
    .POLARITY_OUT(),
    .FRAME_OUT(frame)
  );
  lcdd_panel_model panel (
    .clk_in(clk),
    .com_sel_in(com_sel),
    .seg_on_in(seg_on),
    .drive_en_in(drive_en),
    .lit_out(lit)
  );
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task chk(input [79:0] got, input [79:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task wr_reg(input [15:0] a, input [3:0] d);
  begin
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    repeat (2) @(negedge clk);
  end
  endtask
  task rd_chk(input [15:0] a, input [3:0] e);
  begin
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk({76'h0, rdata}, {76'h0, e});
  end
  endtask
  // bounded wait, returns cycles since the call
  task wait_frame;
  begin
    cyc = 1;
    @(negedge clk);
    while (frame !== 1'b1 && cyc < 5000)
    begin
      @(negedge clk);
      cyc = cyc + 1;
    end
  end
  endtask
  task tally_and_finish;
  begin
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_reset;
  begin
    rd_chk(16'hff60, 4'h0);
    rd_chk(16'hff61, 4'h4);
    rd_chk(16'hf014, 4'h0);
    chk({60'h0, seg_on}, 80'h0);
    wr_reg(16'hff60, 4'hf);
    rd_chk(16'hff60, 4'hd);
    wr_reg(16'hff61, 4'hc);
    rd_chk(16'hff61, 4'h4);
    wr_reg(16'hff60, 4'h0);
    $display("t_reset done");
  end
  endtask
  task t_mem;
  begin
    for (n = 0; n < 20; n = n + 1)
      pat[n*4 +: 4] = 4'h1 << (n % 4);
    pat[71:68] = 4'h0;
    pat[75:72] = 4'h5;
    pat[79:76] = 4'h0;
    for (n = 0; n < 20; n = n + 1)
      wr_reg(16'hf000 + n[15:0], pat[n*4 +: 4]);
    rd_chk(16'hf005, pat[23:20]);
    chk({60'h0, dc_mode}, 80'hc0003);
    chk({60'h0, dc_lvl}, 80'h40001);
    $display("t_mem done");
  end
  endtask
  task t_drive;
  begin
    wr_reg(16'hff60, 4'h1);
    wr_reg(16'hff61, 4'h0);
    chk({79'h0, drive_en}, 80'h1);
    chk({60'h0, dc_lvl}, 80'h40001);
    sleep = 1'b1;
    repeat (3) @(negedge clk);
    chk({75'h0, drive_en, com_sel}, 80'h0);
    rd_chk(16'hff60, 4'h1);
    sleep = 1'b0;
    wr_reg(16'hff60, 4'h0);
    chk({75'h0, drive_en, com_use}, 80'h0);
    chk({60'h0, dc_lvl}, 80'h40001);
    $display("t_drive done");
  end
  endtask
  task t_frames;
  begin
    for (n = 3; n >= 0; n = n - 1)
    begin
      wr_reg(16'hff60, {n[1:0], 2'h1});
      wait_frame;
      wait_frame;
      chk(cyc, (n == 1) ? 3072 : 4096);
      chk({76'h0, com_use}, n[1] ? 4'h3 : (n[0] ? 4'h7 : 4'hf));
      chk({76'h0, com_sel}, 80'h1);
    end
    chk(lit & 80'h00ffffffffffffffff00, pat & 80'h00ffffffffffffffff00);
    $display("t_frames done");
  end
  endtask
  task t_override;
  begin
    wr_reg(16'hff61, 4'h2);
    chk({60'h0, seg_on & 20'h3fffc}, 80'h3fffc);
    wr_reg(16'hff61, 4'h6);
    chk({60'h0, seg_on & 20'h3fffc}, 80'h3fffc);
    wr_reg(16'hff61, 4'h4);
    chk({60'h0, seg_on & 20'h3fffc}, 80'h0);
    wr_reg(16'hff61, 4'h0);
    rd_chk(16'hf005, pat[23:20]);
    wr_reg(16'hff61, 4'h1);
    chk({76'h0, com_sel}, 80'hf);
    chk({60'h0, seg_on & 20'h3fffc}, 80'h1fffc);
    $display("t_override done");
  end
  endtask
  initial
  begin
    #1500000;
    err_count = err_count + 1;
    tally_and_finish;
  end
  initial
  begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_reset;
    t_mem;
    t_drive;
    t_frames;
    t_override;
    tally_and_finish;
  end
endmodule // test_lcdd_top

// ### src/lcdd_defines.vh
`ifndef LCDD_DEFINES_VH
`define LCDD_DEFINES_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define LCDD_ADDR_POWER_DUTY 16'hff60
`define LCDD_ADDR_OVERRIDE 16'hff61
`define LCDD_ADDR_MEM_FIRST 16'hf000
`define LCDD_ADDR_MEM_LAST 16'hf013

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LCDD_BIT_BIAS_POWER 0
`define LCDD_BIT_DUTY_LO 2
`define LCDD_BIT_DUTY_HI 3
`define LCDD_BIT_STATIC 0
`define LCDD_BIT_ALL_ON 1
`define LCDD_BIT_ALL_OFF 2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LCDD_RST_BIAS_POWER 1'b0
`define LCDD_RST_DUTY 2'h0
`define LCDD_RST_STATIC 1'b0
`define LCDD_RST_ALL_ON 1'b0
`define LCDD_RST_ALL_OFF 1'b1

// ----------------------------------------------------------------
// geometry and timing, counted in prescaler ticks
// ----------------------------------------------------------------
`define LCDD_NUM_SEG 20
`define LCDD_NUM_COM 4
`define LCDD_NUM_WORDS 20
`define LCDD_FRAME_TICKS_QUARTER 12'hfff
`define LCDD_FRAME_TICKS_THIRD 12'hbff
`define LCDD_DUTY_QUARTER 2'h0
`define LCDD_DUTY_THIRD 2'h1

`endif

// ### src/lcdd_disp_mem.v
`timescale 1ns/1ps
`include "lcdd_defines.vh"

module lcdd_disp_mem
(
  input wire clk_in,
  input wire wr_in,
  input wire rd_in,
  input wire [4:0] index_in,
  input wire [3:0] wdata_in,
  output reg [3:0] rdata_out,
  output wire [79:0] flat_out
);

  // ----------------------------------------------------------------
  // storage, no reset: contents are undefined until software fills it
  // ----------------------------------------------------------------
  reg [3:0] word_r [0:`LCDD_NUM_WORDS-1];

  genvar w;
  generate
    for (w = 0; w < `LCDD_NUM_WORDS; w = w + 1)
    begin : g_word
      always @(posedge clk_in)
      begin
        if (wr_in && (index_in == w))
          word_r[w] <= wdata_in;
      end
      assign flat_out[w*4 +: 4] = word_r[w];
    end
  endgenerate

  // ----------------------------------------------------------------
  // cpu read port
  // ----------------------------------------------------------------
  always @(posedge clk_in)
  begin
    if (rd_in)
      rdata_out <= word_r[index_in];
  end

endmodule // lcdd_disp_mem

// ### src/lcdd_frame_div.v
`timescale 1ns/1ps
`include "lcdd_defines.vh"

module lcdd_frame_div
(
  input wire clk_in,
  input wire rst_n_in,
  input wire tick_in,
  input wire [1:0] duty_in,
  output reg [1:0] slot_out,
  output reg frame_out,
  output reg polarity_out
);

  reg [11:0] cnt_r;
  reg [11:0] cnt_nxt;
  reg [11:0] last;
  reg [1:0] slot_nxt;

  // ----------------------------------------------------------------
  // frame length and slot decode
  // ----------------------------------------------------------------
  always @*
  begin
    last = `LCDD_FRAME_TICKS_QUARTER;
    if (duty_in == `LCDD_DUTY_THIRD)
      last = `LCDD_FRAME_TICKS_THIRD;
    cnt_nxt = cnt_r + 12'h001;
    // duty change mid-frame may leave cnt beyond the new end
    if (cnt_r >= last)
      cnt_nxt = 12'h000;
    // one slot per common in use
    if (duty_in[1])
      slot_nxt = {1'b0, cnt_nxt[11]};
    else
      slot_nxt = cnt_nxt[11:10];
  end

  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r <= 12'h000;
      slot_out <= 2'h0;
      frame_out <= 1'b0;
      polarity_out <= 1'b0;
    end
    else
    begin
      frame_out <= 1'b0;
      if (tick_in)
      begin
        cnt_r <= cnt_nxt;
        slot_out <= slot_nxt;
        if (cnt_nxt == 12'h000)
        begin
          frame_out <= 1'b1;
          polarity_out <= ~polarity_out;
        end
      end
    end
  end

endmodule // lcdd_frame_div

// ### src/lcdd_top.v
// Behaviour
// - all-on bit set forces ON waveform on every segment not in dc mode.
// - all-off bit alone forces OFF waveform; both clear gives normal.
// - all-on wins when both override bits are set.
// - overrides never touch display memory contents.
// - duty field: hi=1 half, 01 third, 00 quarter.
// - quarter and half duty frame every 4096 prescaler ticks.
// - third duty frame every 3072 prescaler ticks.
// - static mode: ON if any bit of a common in use is set, else OFF.
// - static bit clear uses multiplexed drive by duty.
// - display memory is twenty 4-bit words, F000 to F013.
// - fixed decoder maps any memory bit to any segment and slot.
// - bias power bit off grounds all common outputs and the segment outputs of non-dc pins.
// - dc output pins ignore the bias power bit.
// - sleep grounds the same outputs as power off but keeps bias power bit.
// - dc pin shows its common-0 memory bit as a level.
// - dc mode chosen per pin pair 2n and 2n+1.
// - reset sets all-off, clears duty, static, all-on, power.
// - unused control bits ignore writes and read zero.
`timescale 1ns/1ps
`include "lcdd_defines.vh"

module lcdd_top
#(
  parameter [9:0] DC_PAIR_MASK = 10'h000,
  parameter [559:0] SEG_MAP = lcdd_default_map(1'b0)
)
(
  input wire REF_CLK_IN,
  input wire RST_N_IN,
  input wire PRS_TICK_IN,
  input wire SLEEP_IN,
  input wire [15:0] MEM_ADDR_IN,
  input wire [3:0] MEM_WDATA_IN,
  input wire MEM_WR_IN,
  input wire MEM_RD_IN,
  output wire [3:0] MEM_RDATA_OUT,
  output reg [3:0] COM_SELECT_OUT,
  output reg [3:0] COM_IN_USE_OUT,
  output reg [19:0] SEG_ON_OUT,
  output reg [19:0] SEG_DC_MODE_OUT,
  output reg [19:0] SEG_DC_LEVEL_OUT,
  output reg DRIVE_EN_OUT,
  output reg STATIC_MODE_OUT,
  output reg POLARITY_OUT,
  output reg FRAME_OUT
);

  // ----------------------------------------------------------------
  // default decoder: segment s, slot c reads word s bit c
  // ----------------------------------------------------------------
  function [559:0] lcdd_default_map;
    input dummy;
    integer s;
    integer c;
    begin
      lcdd_default_map = 560'h0;
      for (s = 0; s < 20; s = s + 1)
        for (c = 0; c < 4; c = c + 1)
          lcdd_default_map[(s*4+c)*7 +: 7] = {s[4:0], c[1:0]};
    end
  endfunction

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  reg bias_power_r;
  reg [1:0] duty_r;
  reg static_r;
  reg all_on_r;
  reg all_off_r;
  reg [3:0] ctrl_rdata_r;
  reg sel_mem_r;
  reg [3:0] ctrl_rdata_nxt;

  wire hit_power = (MEM_ADDR_IN == `LCDD_ADDR_POWER_DUTY);
  wire hit_override = (MEM_ADDR_IN == `LCDD_ADDR_OVERRIDE);
  wire hit_mem = (MEM_ADDR_IN >= `LCDD_ADDR_MEM_FIRST) &&
                 (MEM_ADDR_IN <= `LCDD_ADDR_MEM_LAST);
  wire [4:0] mem_index = MEM_ADDR_IN[4:0];
  // only cpu writes reach the memory
  wire mem_wr = MEM_WR_IN & hit_mem;
  wire mem_rd = MEM_RD_IN & hit_mem;

  always @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      bias_power_r <= `LCDD_RST_BIAS_POWER;
      duty_r <= `LCDD_RST_DUTY;
      static_r <= `LCDD_RST_STATIC;
      all_on_r <= `LCDD_RST_ALL_ON;
      all_off_r <= `LCDD_RST_ALL_OFF;
    end
    else if (MEM_WR_IN)
    begin
      // only the defined bits are stored
      if (hit_power)
      begin
        bias_power_r <= MEM_WDATA_IN[`LCDD_BIT_BIAS_POWER];
        duty_r <= {MEM_WDATA_IN[`LCDD_BIT_DUTY_HI],
                   MEM_WDATA_IN[`LCDD_BIT_DUTY_LO]};
      end
      if (hit_override)
      begin
        static_r <= MEM_WDATA_IN[`LCDD_BIT_STATIC];
        all_on_r <= MEM_WDATA_IN[`LCDD_BIT_ALL_ON];
        all_off_r <= MEM_WDATA_IN[`LCDD_BIT_ALL_OFF];
      end
    end
  end

  // ----------------------------------------------------------------
  // read path, one cycle after the read strobe
  // ----------------------------------------------------------------
  always @*
  begin
    // unused positions read zero, so does an unmapped address
    ctrl_rdata_nxt = 4'h0;
    if (hit_power)
      ctrl_rdata_nxt = {duty_r[1], duty_r[0], 1'b0, bias_power_r};
    if (hit_override)
      ctrl_rdata_nxt = {1'b0, all_off_r, all_on_r, static_r};
  end

  always @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      ctrl_rdata_r <= 4'h0;
      sel_mem_r <= 1'b0;
    end
    else if (MEM_RD_IN)
    begin
      sel_mem_r <= hit_mem;
      ctrl_rdata_r <= ctrl_rdata_nxt;
    end
  end

  wire [3:0] mem_rdata;
  wire [79:0] mem_flat;

  // both sources are registered, only the select is muxed
  assign MEM_RDATA_OUT = sel_mem_r ? mem_rdata : ctrl_rdata_r;

  // ----------------------------------------------------------------
  // display memory
  // ----------------------------------------------------------------
  lcdd_disp_mem u_mem
  (
    .clk_in(REF_CLK_IN),
    .wr_in(mem_wr),
    .rd_in(mem_rd),
    .index_in(mem_index),
    .wdata_in(MEM_WDATA_IN),
    .rdata_out(mem_rdata),
    .flat_out(mem_flat)
  );

  // ----------------------------------------------------------------
  // frame timing
  // ----------------------------------------------------------------
  // ticks are one-cycle enables from the prescaler, same clock
  wire [1:0] slot;
  wire frame_pulse;
  wire polarity;

  lcdd_frame_div u_div
  (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RST_N_IN),
    .tick_in(PRS_TICK_IN),
    .duty_in(duty_r),
    .slot_out(slot),
    .frame_out(frame_pulse),
    .polarity_out(polarity)
  );

  // ----------------------------------------------------------------
  // segment decoder and per-segment drive
  // ----------------------------------------------------------------
  // power gate; sleep gates without touching the bit
  wire drive_en = bias_power_r & ~SLEEP_IN;
  reg [3:0] in_use;
  reg [3:0] slot_onehot;
  reg [3:0] act_slot;
  reg [3:0] com_sel;
  wire [79:0] pattern;
  wire [19:0] seg_wave;
  wire [19:0] seg_dc_mode;

  always @*
  begin
    if (duty_r[1])
      in_use = 4'h3;
    else if (duty_r[0])
      in_use = 4'h7;
    else
      in_use = 4'hf;
  end

  always @*
  begin
    case (slot)
      2'h0: slot_onehot = 4'h1;
      2'h1: slot_onehot = 4'h2;
      2'h2: slot_onehot = 4'h4;
      2'h3: slot_onehot = 4'h8;
      default: slot_onehot = 4'h1;
    endcase
  end

  // ----------------------------------------------------------------
  // active common
  // ----------------------------------------------------------------
  always @*
  begin
    // slot left over from a wider duty falls back to common 0
    // the divider only corrects it on its next tick
    act_slot = slot_onehot & in_use;
    if (act_slot == 4'h0)
      act_slot = 4'h1;
    // static mode drives every used common alike
    if (static_r)
      com_sel = in_use;
    else
      com_sel = act_slot;
    // grounded commons while power off or asleep
    if (!drive_en)
      com_sel = 4'h0;
  end

  genvar g;
  generate
    for (g = 0; g < 80; g = g + 1)
    begin : g_map
      // fixed bit allocation per segment and slot
      assign pattern[g] = mem_flat[SEG_MAP[g*7+2 +: 5]*4 +
                                   SEG_MAP[g*7 +: 2]];
    end
    for (g = 0; g < 20; g = g + 1)
    begin : g_seg
      wire [3:0] bits = pattern[g*4 +: 4];
      // static lights on any used slot bit
      wire lit_static = |(bits & in_use);
      // dynamic lights the bit of the active slot
      wire lit_dyn = |(bits & act_slot);
      wire lit = static_r ? lit_static : lit_dyn;
      // all on; all on before all off; all off
      assign seg_wave[g] = all_on_r | (~all_off_r & lit);
      // pair 2n and 2n+1 share the mode
      assign seg_dc_mode[g] = DC_PAIR_MASK[g/2];
    end
  endgenerate

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  always @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      COM_SELECT_OUT <= 4'h0;
      COM_IN_USE_OUT <= 4'h0;
      SEG_ON_OUT <= 20'h0;
      SEG_DC_MODE_OUT <= 20'h0;
      SEG_DC_LEVEL_OUT <= 20'h0;
      DRIVE_EN_OUT <= 1'b0;
      STATIC_MODE_OUT <= 1'b0;
      POLARITY_OUT <= 1'b0;
      FRAME_OUT <= 1'b0;
    end
    else
    begin
      DRIVE_EN_OUT <= drive_en;
      STATIC_MODE_OUT <= static_r;
      POLARITY_OUT <= polarity;
      FRAME_OUT <= frame_pulse;
      SEG_DC_MODE_OUT <= seg_dc_mode;
      // grounded commons while power off or asleep
      COM_IN_USE_OUT <= drive_en ? in_use : 4'h0;
      COM_SELECT_OUT <= com_sel;
      // segment waveforms grounded too; dc pins excluded
      SEG_ON_OUT <= drive_en ? (seg_wave & ~seg_dc_mode) : 20'h0;
      // dc level is the common-0 bit of each pin
      SEG_DC_LEVEL_OUT <= seg_dc_mode & {pattern[76], pattern[72],
        pattern[68], pattern[64], pattern[60], pattern[56],
        pattern[52], pattern[48], pattern[44], pattern[40],
        pattern[36], pattern[32], pattern[28], pattern[24],
        pattern[20], pattern[16], pattern[12], pattern[8],
        pattern[4], pattern[0]};
    end
  end

endmodule // lcdd_top
